// ==== core/smr_pkg.sv ====
// package: register map, field layout, reset values and decode types
package smr_pkg;

   // ------------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------------
   localparam logic [5:0] ADDR_LATENCY  = 6'h02;
   localparam logic [5:0] ADDR_DRIVE    = 6'h03;
   localparam logic [5:0] ADDR_THERMAL  = 6'h04;
   localparam logic [5:0] ADDR_MAKER    = 6'h05;
   localparam logic [5:0] ADDR_REV_ONE  = 6'h06;
   localparam logic [5:0] ADDR_REV_TWO  = 6'h07;
   localparam logic [5:0] ADDR_GEOMETRY = 6'h08;
   localparam logic [5:0] ADDR_TEST     = 6'h09;
   localparam logic [5:0] ADDR_ZQ       = 6'h0a;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int WLS_BIT       = 6;
   localparam int WRLEV_BIT     = 7;
   localparam int PUCAL_BIT     = 0;
   localparam int PST_BIT       = 1;
   localparam int PROT_BIT      = 2;
   localparam int PULLDOWN_STRENGTH_LSB      = 3;
   localparam int RDBI_BIT      = 6;
   localparam int WDBI_BIT      = 7;
   localparam int SRA_BIT       = 3;
   localparam int REPAIR_ENTRY_BIT      = 4;
   localparam int TOFS_LSB      = 5;
   localparam int TUF_BIT       = 7;
   localparam int ZQRST_BIT     = 0;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_LATENCY = 8'h00;
   localparam logic [7:0] RST_DRIVE   = 8'h31;
   localparam logic [2:0] RST_RATE    = 3'h3;
   localparam logic [2:0] RATE_DERATE = 3'h6;
   localparam logic [2:0] PULLDOWN_STRENGTH_LO     = 3'h1;
   localparam logic [2:0] PULLDOWN_STRENGTH_HI     = 3'h6;
   localparam logic [1:0] TOFS_RSVD   = 2'h3;

   // ------------------------------------------------------------------
   // identity and geometry (values arbitrary)
   // ------------------------------------------------------------------
   localparam logic [7:0] MAKER_CODE  = 8'h5c;
   localparam logic [7:0] REV_ONE     = 8'h02;
   localparam logic [7:0] REV_TWO     = 8'h03;
   localparam logic [1:0] GEO_TYPE    = 2'h0;
   localparam logic [3:0] GEO_DENSITY = 4'h0;
   localparam logic [1:0] GEO_WIDTH   = 2'h0;

   // ------------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [5:0] read_latency;
      logic [4:0] read_to_precharge;
      logic [5:0] write_latency;
      logic       write_postamble_len;
      logic [2:0] pulldown_strength;
      logic       pullup_cal_point;
      logic       read_bus_inversion;
      logic       write_bus_inversion;
   } smr_timing_s;

   typedef struct packed {
      logic       selfrefresh_abort;
      logic       repair_entry;
      logic [1:0] thermal_offset;
      logic       repair_protection;
      logic       write_leveling;
      logic       impedance_cal_reset_bit;
   } smr_ctrl_s;

   typedef enum logic {SMR_IDLE, SMR_LEVELING} smr_state_e;

endpackage

// ==== core/smr_bank.sv ====
// mode register bank: two set points, latency decode, thermal status
// Functional notes
// - decode read latency, inversion off
// - decode read latency, inversion on
// - write latency set A table
// - write latency set B table
// - bit 6 selects write latency set
// - write leveling holds until cleared by write
// - writes reach copy chosen by write select
// - operation uses copy chosen by operating select
// - bit 1 selects write postamble length
// - pull-down strength codes one to six
// - repair protection sticky until power-on reset
// - protection refuses setting repair entry
// - refresh rate field reports eight codes
// - derating needed reports code six
// - refresh rate valid after initialization
// - update flag set on change, read clears
// - thermal write updates only bits six..three
// - thermal abort, repair entry, offset fields
// - geometry reports type, density, width
// - impedance reset bit resets calibration
// - read and write commands, access limits
`timescale 1ns/1ps
`default_nettype none

module smr_bank
   import smr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        mrw_valid,
   input  wire logic        mrr_valid,
   input  wire logic [5:0]  mr_addr,
   input  wire logic [7:0]  mr_wdata,
   input  wire logic        write_set_point_select,
   input  wire logic        operating_set_point_select,
   input  wire logic        init_done,
   input  wire logic [2:0]  sensor_rate,
   input  wire logic        derate_needed,
   output logic             mrr_rvalid,
   output logic [7:0]       mrr_rdata,
   output logic             leveling_active,
   output logic             rate_valid,
   output smr_timing_s      timing,
   output smr_ctrl_s        ctrl
);

   // ------------------------------------------------------------------
   // set point copies
   // ------------------------------------------------------------------
   logic [7:0] lat_q [2];
   logic [7:0] drv_q [2];
   logic       wr_lat;
   logic       wr_drv;
   logic       wsp;
   logic       osp;

   assign wsp    = write_set_point_select;
   assign osp    = operating_set_point_select;
   assign wr_lat = mrw_valid && (mr_addr == ADDR_LATENCY);
   assign wr_drv = mrw_valid && (mr_addr == ADDR_DRIVE);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_fsp
         always_ff @(posedge clk) begin
            if (reset) begin
               lat_q[gi] <= RST_LATENCY;
               drv_q[gi] <= RST_DRIVE;
            end else begin
               if (wr_lat && (wsp == (gi == 1))) begin
                  lat_q[gi] <= mr_wdata;
               end
               if (wr_drv && (wsp == (gi == 1))) begin
                  drv_q[gi] <= mr_wdata;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // active copy decode
   // ------------------------------------------------------------------
   logic [7:0] lat_a;
   logic [7:0] drv_a;
   logic [2:0] rl_code;
   logic [2:0] wl_code;
   logic [2:0] pd_code;

   assign lat_a   = lat_q[osp];
   assign drv_a   = drv_q[osp];
   assign rl_code = lat_a[2:0];
   assign wl_code = lat_a[5:3];
   assign pd_code = drv_a[PULLDOWN_STRENGTH_LSB +: 3];

   function automatic logic [5:0] rl_dec(input logic [2:0] c,
                                         input logic       dbi);
      logic [5:0] r;
      r = 6'h06;
      if (!dbi) begin
         unique case (c)
            3'h0: r = 6'd6;
            3'h1: r = 6'd10;
            3'h2: r = 6'd14;
            3'h3: r = 6'd20;
            3'h4: r = 6'd24;
            3'h5: r = 6'd28;
            3'h6: r = 6'd32;
            3'h7: r = 6'd36;
         endcase
      end else begin
         unique case (c)
            3'h0: r = 6'd6;
            3'h1: r = 6'd12;
            3'h2: r = 6'd16;
            3'h3: r = 6'd22;
            3'h4: r = 6'd28;
            3'h5: r = 6'd32;
            3'h6: r = 6'd36;
            3'h7: r = 6'd40;
         endcase
      end
      return r;
   endfunction

   function automatic logic [5:0] wl_dec(input logic [2:0] c,
                                         input logic       setb);
      logic [5:0] r;
      r = 6'h04;
      if (!setb) begin
         r = {2'h0, c, 1'b0} + 6'd4;
      end else begin
         unique case (c)
            3'h0: r = 6'd4;
            3'h1: r = 6'd8;
            3'h2: r = 6'd12;
            3'h3: r = 6'd18;
            3'h4: r = 6'd22;
            3'h5: r = 6'd26;
            3'h6: r = 6'd30;
            3'h7: r = 6'd34;
         endcase
      end
      return r;
   endfunction

   logic [5:0]  rl_next;
   logic [5:0]  wl_next;
   logic [4:0]  rtp_next;

   assign rl_next  = rl_dec(rl_code, drv_a[RDBI_BIT]);
   assign wl_next  = wl_dec(wl_code, lat_a[WLS_BIT]);
   assign rtp_next = rl_code[2] ? {1'b0, rl_code[1:0], 1'b0} + 5'd10
                                : 5'd8;

   always_ff @(posedge clk) begin
      if (reset) begin
         // decoded defaults, so range checks hold from the first edge
         timing                   <= '0;
         timing.read_latency      <= 6'd6;
         timing.read_to_precharge <= 5'd8;
         timing.write_latency     <= 6'd4;
         timing.pulldown_strength <= RST_DRIVE[PULLDOWN_STRENGTH_LSB +: 3];
         timing.pullup_cal_point  <= RST_DRIVE[PUCAL_BIT];
      end else begin
         timing.read_latency        <= rl_next;
         timing.read_to_precharge   <= rtp_next;
         timing.write_latency       <= wl_next;
         timing.write_postamble_len <= drv_a[PST_BIT];
         timing.pullup_cal_point    <= drv_a[PUCAL_BIT];
         timing.read_bus_inversion  <= drv_a[RDBI_BIT];
         timing.write_bus_inversion <= drv_a[WDBI_BIT];
         if (pd_code >= PULLDOWN_STRENGTH_LO && pd_code <= PULLDOWN_STRENGTH_HI) begin
            timing.pulldown_strength <= pd_code;
         end
      end
   end

   // ------------------------------------------------------------------
   // write leveling state
   // ------------------------------------------------------------------
   smr_state_e state_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= SMR_IDLE;
      end else if (wr_lat) begin
         state_q <= mr_wdata[WRLEV_BIT] ? SMR_LEVELING : SMR_IDLE;
      end
   end

   assign leveling_active = (state_q == SMR_LEVELING);

   // ------------------------------------------------------------------
   // protection, thermal controls, calibration reset
   // ------------------------------------------------------------------
   logic prot_q;
   logic wr_thm;

   assign wr_thm = mrw_valid && (mr_addr == ADDR_THERMAL);

   always_ff @(posedge clk) begin
      if (reset) begin
         prot_q <= 1'b0;
      end else if (wr_drv && mr_wdata[PROT_BIT]) begin
         prot_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl.selfrefresh_abort <= 1'b0;
         ctrl.repair_entry      <= 1'b0;
         ctrl.thermal_offset    <= 2'h0;
      end else if (wr_thm) begin
         ctrl.selfrefresh_abort <= mr_wdata[SRA_BIT];
         if (!(prot_q && mr_wdata[REPAIR_ENTRY_BIT])) begin
            ctrl.repair_entry <= mr_wdata[REPAIR_ENTRY_BIT];
         end
         if (mr_wdata[TOFS_LSB +: 2] != TOFS_RSVD) begin
            ctrl.thermal_offset <= mr_wdata[TOFS_LSB +: 2];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl.impedance_cal_reset_bit <= 1'b0;
      end else if (mrw_valid && mr_addr == ADDR_ZQ) begin
         ctrl.impedance_cal_reset_bit <= mr_wdata[ZQRST_BIT];
      end
   end

   assign ctrl.repair_protection = prot_q;
   assign ctrl.write_leveling    = leveling_active;

   // ------------------------------------------------------------------
   // refresh rate and update flag
   // ------------------------------------------------------------------
   logic [2:0] rate_q;
   logic [2:0] rate_in;
   logic       tuf_q;
   logic       rd_thm;
   logic       rate_chg;

   assign rate_in  = derate_needed ? RATE_DERATE : sensor_rate;
   assign rd_thm   = mrr_valid && (mr_addr == ADDR_THERMAL);
   assign rate_chg = init_done && (rate_in != rate_q);

   always_ff @(posedge clk) begin
      if (reset) begin
         rate_q <= RST_RATE;
      end else if (init_done) begin
         rate_q <= rate_in;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tuf_q <= 1'b0;
      end else if (rate_chg) begin
         tuf_q <= 1'b1;
      end else if (rd_thm) begin
         tuf_q <= 1'b0;
      end
   end

   assign rate_valid = init_done;

   // ------------------------------------------------------------------
   // mode register read
   // ------------------------------------------------------------------
   logic [7:0] rd_d;

   always_comb begin
      rd_d = 8'h00;
      unique case (mr_addr)
         ADDR_THERMAL:  rd_d = {tuf_q, 4'h0, rate_q};
         ADDR_MAKER:    rd_d = MAKER_CODE;
         ADDR_REV_ONE:  rd_d = REV_ONE;
         ADDR_REV_TWO:  rd_d = REV_TWO;
         ADDR_GEOMETRY: rd_d = {GEO_WIDTH, GEO_DENSITY, GEO_TYPE};
         default:       rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mrr_rvalid <= 1'b0;
         mrr_rdata  <= 8'h00;
      end else begin
         mrr_rvalid <= mrr_valid;
         mrr_rdata  <= mrr_valid ? rd_d : 8'h00;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   AST_TUF_SET: assert property (@(posedge clk) disable iff (reset)
      rate_chg |=> tuf_q)
      else $error("update flag not set on rate change");
   AST_TUF_CLR: assert property (@(posedge clk) disable iff (reset)
      rd_thm && !rate_chg |=> !tuf_q)
      else $error("update flag not cleared by read");
   AST_PROT_STICKY: assert property (@(posedge clk) disable iff (reset)
      prot_q |=> prot_q)
      else $error("protection bit dropped");
   AST_REPAIR_ENTRY_BLOCK: assert property (@(posedge clk) disable iff (reset)
      prot_q && !ctrl.repair_entry |=> !ctrl.repair_entry)
      else $error("repair entry set while protected");
   AST_LEV_HOLD: assert property (@(posedge clk) disable iff (reset)
      leveling_active && !wr_lat |=> leveling_active)
      else $error("leveling left without clearing write");
   AST_RL_MIN: assert property (@(posedge clk) disable iff (reset)
      timing.read_latency >= 6'd6 && timing.read_latency <= 6'd40)
      else $error("read latency out of range");
   AST_WL_A: assert property (@(posedge clk) disable iff (reset)
      !lat_a[WLS_BIT] && $stable(lat_a) |=>
      timing.write_latency == 6'd4 + {2'h0, $past(wl_code), 1'b0})
      else $error("write latency set A wrong");
   AST_PULLDOWN_STRENGTH: assert property (@(posedge clk) disable iff (reset)
      timing.pulldown_strength >= PULLDOWN_STRENGTH_LO &&
      timing.pulldown_strength <= PULLDOWN_STRENGTH_HI)
      else $error("pull-down strength reserved");
   AST_MRR: assert property (@(posedge clk) disable iff (reset)
      mrr_valid && mr_addr == ADDR_MAKER |=> mrr_rdata == MAKER_CODE)
      else $error("maker code read wrong");

endmodule

`default_nettype wire

// ==== verif/smr_host_model.sv ====
// controller-side model issuing mode register reads and writes
`timescale 1ns/1ps
`default_nettype none

module smr_host_model
   import smr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       leveling_active,
   input  wire logic       mrr_rvalid,
   input  wire logic [7:0] mrr_rdata,
   output logic            mrw_valid,
   output logic            mrr_valid,
   output logic [5:0]      mr_addr,
   output logic [7:0]      mr_wdata
);
   initial begin
      mrw_valid = 1'b0;
      mrr_valid = 1'b0;
      mr_addr   = 6'h00;
      mr_wdata  = 8'h00;
   end

   // --------------------------------------------------------------
   // write command, released one cycle later
   // --------------------------------------------------------------
   task automatic mr_write(input logic [5:0] a, input logic [7:0] d);
      @(negedge clk);
      // only the clearing latency write goes out while leveling
      if (leveling_active === 1'b1 && !(a == ADDR_LATENCY && !d[7])) return;
      mrw_valid = 1'b1;
      mr_addr   = a;
      mr_wdata  = (a == ADDR_TEST) ? 8'h00 : d;
      // single channel: one pull-up point programmed here
      @(negedge clk);
      mrw_valid = 1'b0;
      mr_addr   = ~a;
      mr_wdata  = ~mr_wdata;
   endtask

   // --------------------------------------------------------------
   // read command, answer awaited for a bounded number of cycles
   // --------------------------------------------------------------
   task automatic mr_read(input logic [5:0] a, output logic [7:0] d,
                          output logic ok);
      int i;
      ok = 1'b0;
      d  = 8'h00;
      @(negedge clk);
      mrr_valid = 1'b1;
      mr_addr   = a;
      @(negedge clk);
      mrr_valid = 1'b0;
      mr_addr   = ~a;
      for (i = 0; i < 3 && !ok; i++) begin
         if (mrr_rvalid === 1'b1) begin
            ok = 1'b1;
            d  = mrr_rdata;
         end
         else @(negedge clk);
      end
   endtask
endmodule

`default_nettype wire

// ==== verif/smr_bank_bench.sv ====
// self-checking bench for the mode register bank
`timescale 1ns/1ps
`default_nettype none

module smr_bank_bench
   import smr_pkg::*;
;
   logic        clk, reset, wsp, osp, init_done, derate, rvalid, lev;
   logic        mrw_valid, mrr_valid, rate_valid;
   logic [5:0]  mr_addr;
   logic [7:0]  mr_wdata, rdata;
   logic [2:0]  sensor_rate;
   smr_timing_s tim;
   smr_ctrl_s   ctl;
   int          n_errors, samples_checked, k, c;
   int rl_tab [16] = '{6,10,14,20,24,28,32,36,6,12,16,22,28,32,36,40};
   int wl_tab [16] = '{4,6,8,10,12,14,16,18,4,8,12,18,22,26,30,34};
   int rtp_tab [8] = '{8,8,8,8,10,12,14,16};

   smr_bank smr_bank_inst (.clk(clk), .reset(reset), .mrw_valid(mrw_valid),
      .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
      .write_set_point_select(wsp), .operating_set_point_select(osp),
      .init_done(init_done), .sensor_rate(sensor_rate),
      .derate_needed(derate), .mrr_rvalid(rvalid), .mrr_rdata(rdata),
      .leveling_active(lev), .rate_valid(rate_valid), .timing(tim),
      .ctrl(ctl));

   smr_host_model smr_host_model_inst (.clk(clk), .leveling_active(lev),
      .mrr_rvalid(rvalid), .mrr_rdata(rdata), .mrw_valid(mrw_valid),
      .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata));

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      smr_host_model_inst.mr_write(a, d);
      repeat (3) @(negedge clk);
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       ok;
      smr_host_model_inst.mr_read(a, d, ok);
      check(ok, 1'b1);
      check(d, e);
   endtask

   initial begin
      #100000;
      n_errors++;
      test_done();
   end

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   initial begin
      n_errors = 0;
      samples_checked = 0;
      {reset, wsp, osp, init_done, derate} = 5'b10000;
      sensor_rate = 3'h3;
      repeat (3) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      check(tim.read_latency, 6);
      check(tim.read_to_precharge, 8);
      check(tim.write_latency, 4);
      check(tim.write_postamble_len, 0);
      check(tim.pulldown_strength, 6);
      check(tim.pullup_cal_point, 1);
      check(ctl, 0);
      check(lev, 0);
      for (k = 0; k < 2; k++) begin
         for (c = 0; c < 8; c++) begin
            wr(ADDR_DRIVE, RST_DRIVE | {1'b0, k[0], 6'h00});
            wr(ADDR_LATENCY, {1'b0, k[0], c[2:0], c[2:0]});
            check(tim.read_latency, rl_tab[k*8+c]);
            check(tim.read_to_precharge, rtp_tab[c]);
            check(tim.write_latency, wl_tab[k*8+c]);
         end
      end
      wsp = 1'b1;
      wr(ADDR_LATENCY, 8'h09);
      wr(ADDR_DRIVE, RST_DRIVE);
      check(tim.read_latency, 40);
      osp = 1'b1;
      repeat (3) @(negedge clk);
      check(tim.read_latency, 10);
      check(tim.write_latency, 6);
      {wsp, osp} = 2'b00;
      wr(ADDR_LATENCY, 8'h80);
      check(lev, 1);
      check(ctl.write_leveling, 1);
      wr(ADDR_THERMAL, 8'h08);
      check(ctl.selfrefresh_abort, 0);
      wr(ADDR_LATENCY, 8'h00);
      check(lev, 0);
      wr(ADDR_DRIVE, 8'h93);
      check(tim.write_postamble_len, 1);
      check(tim.pulldown_strength, 2);
      check({tim.write_bus_inversion, tim.read_bus_inversion}, 2);
      wr(ADDR_DRIVE, 8'h83);
      check(tim.pulldown_strength, 2);
      wr(ADDR_DRIVE, 8'hbb);
      check(tim.pulldown_strength, 2);
      rd(ADDR_THERMAL, 8'h03);
      check(rate_valid, 0);
      init_done = 1'b1;
      for (c = 0; c < 8; c++) begin
         sensor_rate = c[2:0];
         repeat (3) @(negedge clk);
         rd(ADDR_THERMAL, {1'b1, 4'h0, c[2:0]});
         rd(ADDR_THERMAL, {1'b0, 4'h0, c[2:0]});
      end
      check(rate_valid, 1);
      sensor_rate = 3'h1;
      derate = 1'b1;
      repeat (3) @(negedge clk);
      rd(ADDR_THERMAL, 8'h86);
      wr(ADDR_THERMAL, 8'hff);
      check({ctl.thermal_offset, ctl.repair_entry, ctl.selfrefresh_abort},
            3);
      rd(ADDR_THERMAL, 8'h06);
      wr(ADDR_THERMAL, 8'h40);
      check({ctl.thermal_offset, ctl.repair_entry, ctl.selfrefresh_abort},
            8);
      wr(ADDR_DRIVE, 8'h35);
      check(ctl.repair_protection, 1);
      wr(ADDR_DRIVE, 8'h31);
      check(ctl.repair_protection, 1);
      wr(ADDR_THERMAL, 8'h10);
      check(ctl.repair_entry, 0);
      rd(ADDR_MAKER, MAKER_CODE);
      rd(ADDR_REV_ONE, REV_ONE);
      rd(ADDR_REV_TWO, REV_TWO);
      rd(ADDR_GEOMETRY, {GEO_WIDTH, GEO_DENSITY, GEO_TYPE});
      wr(ADDR_MAKER, ~MAKER_CODE);
      rd(ADDR_MAKER, MAKER_CODE);
      rd(ADDR_LATENCY, 8'h00);
      rd(ADDR_ZQ, 8'h00);
      rd(6'h0b, 8'h00);
      wr(ADDR_ZQ, 8'h01);
      check(ctl.impedance_cal_reset_bit, 1);
      wr(ADDR_ZQ, 8'h00);
      check(ctl.impedance_cal_reset_bit, 0);
      wr(ADDR_TEST, 8'h5a);
      test_done();
   end
endmodule

`default_nettype wire
